// ==== pmt_pkg.sv ====
// constants shared by the power module telemetry and status block
// assumes a 250 MHz core clock and a management bus slave in the block
package pmt_pkg;
   // command codes the host uses to reach each register
   localparam logic [7:0] CMD_IGAIN = 8'h38;
   localparam logic [7:0] CMD_IOFF = 8'h39;
   localparam logic [7:0] CMD_SBYTE = 8'h78;
   localparam logic [7:0] CMD_SWORD = 8'h79;
   localparam logic [7:0] CMD_SVOUT = 8'h7a;
   localparam logic [7:0] CMD_RVIN = 8'h88;
   localparam logic [7:0] CMD_RVOUT = 8'h8b;
   localparam logic [7:0] CMD_RIOUT = 8'h8c;
   localparam logic [7:0] CMD_VOFF = 8'hd4;
   localparam logic [7:0] CMD_VGAIN = 8'hd5;
   localparam logic [7:0] CMD_NOFF = 8'hd6;
   localparam logic [7:0] CMD_NGAIN = 8'hd7;
   // fixed linear-format exponents, five-bit two's complement
   localparam logic [4:0] EXP_IGAIN = 5'h11;
   localparam logic [4:0] EXP_IOUT = 5'h1c;
   localparam logic [4:0] EXP_VGAIN = 5'h18;
   localparam logic [4:0] EXP_VIN = 5'h1b;
   // averaging interval and depth
   localparam int INTERVAL_US = 200;
   localparam int CLK_MHZ = 250;
   localparam int INTERVAL_CYC = INTERVAL_US * CLK_MHZ;
   localparam logic [4:0] AVG_N = 5'h10;
   localparam int AVG_SHIFT = 4;
   localparam logic [1:0] CH_IOUT = 2'h0;
   localparam logic [1:0] CH_VOUT = 2'h1;
   localparam logic [1:0] CH_VIN = 2'h2;
   // fault input vector positions
   localparam int F_OFF = 0;
   localparam int F_VOV = 1;
   localparam int F_VUV = 2;
   localparam int F_IOC = 3;
   localparam int F_IOW = 4;
   localparam int F_VINUV = 5;
   localparam int F_TEMP = 6;
   localparam int F_COMM = 7;
   localparam int F_PGN = 8;
   localparam int FLT_W = 9;
   // status bit positions
   localparam int SB_OFF = 6;
   localparam int SB_VOV = 5;
   localparam int SB_IOC = 4;
   localparam int SB_VINUV = 3;
   localparam int SB_TEMP = 2;
   localparam int SB_COMM = 1;
   localparam int SB_NONE = 0;
   localparam int SW_VOUT = 15;
   localparam int SW_IOUT = 14;
   localparam int SW_PGN = 11;
   localparam int SV_OV = 7;
   localparam int SV_UV = 4;
   // clamp limits
   localparam logic signed [15:0] VOFF_MIN = -16'sd128;
   localparam logic signed [15:0] VOFF_MAX = 16'sd127;
   localparam logic [9:0] MANT_MAX = 10'h3ff;
   localparam logic [7:0] RD_IDLE = 8'hff;
endpackage

// ==== pmt_telemetry.sv ====
// power module telemetry averaging, calibration and fault status
// assumes sample link on its own clock and an open-drain host bus
//
// Summary of operation
// [RULE1] every 200 us average 16 samples each of iout, vout, vin
// [RULE2] current gain: exponent -15 in high bits 7:3, 11-bit mantissa
// [RULE3] current offset: exponent -4, 11-bit mantissa, 62.5 mA steps
// [RULE4] host can write and read back the current offset
// [RULE5] factory gain and offset scale sense voltage into current
// [RULE6] sinking current reads as zero
// [RULE7] current reading: exponent -4, 11-bit mantissa, top bit zero
// [RULE8] no temperature compensation of the current reading
// [RULE9] vout reading is 16 bits of mantissa, exponent -10
// [RULE10] vout offset: 16-bit mantissa, exp -10, -125 to 124 mV
// [RULE11] vout and vin gain: exponent -8, 11-bit mantissa
// [RULE12] corrected = raw times (1 + gain) plus offset
// [RULE13] vin reading: exponent -5, 11-bit mantissa, top bit zero
// [RULE14] vin offset: exponent -5, 11-bit mantissa, read and write
// [RULE15] a status bit of one means the condition is flagged
// [RULE16] summary byte bit layout, bit 7 unused, reset zero
// [RULE17] summary word repeats byte low, vout/iout/pgood high
// [RULE18] vout fault byte: overvoltage bit 7, undervoltage bit 4
// [RULE19] host reads averages with bus read commands
// [RULE20] unused status bits zero, readbacks update atomically
// [RULE21] summary bits follow the detailed fault flags
`timescale 1ns/1ns
`default_nettype none
module pmt_telemetry
   import pmt_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = 7'h28,
   parameter int INTERVAL = INTERVAL_CYC,
   parameter logic [10:0] IGAIN_DEF = 11'h000,
   parameter logic [10:0] IOFF_DEF = 11'h000,
   parameter logic [15:0] VOFF_DEF = 16'h0000,
   parameter logic [10:0] VGAIN_DEF = 11'h000,
   parameter logic [10:0] NOFF_DEF = 11'h000,
   parameter logic [10:0] NGAIN_DEF = 11'h000
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic adc_clk_i,
   input wire logic sample_valid_i,
   input wire logic [1:0] sample_chan_i,
   input wire logic [15:0] sample_data_i,
   input wire logic [FLT_W-1:0] fault_i
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA}
      pmt_st_type;

   ////////////////////////////////////////////////////////////////////
   // interval timer in the core domain
   logic [31:0] tmr_r;
   logic req_tgl_r;
   wire tmr_zero = (tmr_r == 32'h0);
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmr_r <= 32'h0;
         req_tgl_r <= 1'b0;
      end else begin
         tmr_r <= tmr_zero ? 32'(INTERVAL - 1) : tmr_r - 32'h1;
         if (tmr_zero) begin
            req_tgl_r <= ~req_tgl_r; // see [RULE1]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link domain: burst of sixteen samples per channel
   logic [1:0] lrst_r;
   logic [2:0] lreq_r;
   logic busy_r;
   logic ldone_r;
   logic [2:0] full;
   logic signed [16:0] hold [3];
   wire lrst_n = lrst_r[1];
   wire lstart = lreq_r[2] ^ lreq_r[1];
   wire lfin = busy_r & (&full);
   // reset released in step with the link clock
   always_ff @(posedge adc_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lrst_r <= 2'b00;
      end else begin
         lrst_r <= {lrst_r[0], 1'b1};
      end
   end
   always_ff @(posedge adc_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         lreq_r <= 3'b000;
         busy_r <= 1'b0;
         ldone_r <= 1'b0;
      end else begin
         lreq_r <= {lreq_r[1:0], req_tgl_r};
         busy_r <= lstart | (busy_r & ~lfin);
         if (lfin && !lstart) begin
            ldone_r <= ~ldone_r; // see [RULE1]
         end
      end
   end
   // one accumulator per channel; the current channel is signed
   for (genvar c = 0; c < 3; c++) begin : g_ch
      logic signed [20:0] acc_r;
      logic [4:0] cnt_r;
      wire signed [16:0] smp = (c == CH_IOUT) ?
         {sample_data_i[15], sample_data_i} : {1'b0, sample_data_i};
      wire take = busy_r & sample_valid_i & ~full[c] &
         (sample_chan_i == 2'(c));
      assign full[c] = (cnt_r == AVG_N);
      always_ff @(posedge adc_clk_i or negedge lrst_n) begin
         if (!lrst_n) begin
            acc_r <= 21'sh0;
            cnt_r <= 5'h0;
            hold[c] <= 17'sh0;
         end else begin
            if (lstart) begin
               acc_r <= 21'sh0;
               cnt_r <= 5'h0;
            end else if (take) begin
               acc_r <= acc_r + 21'(smp); // see [RULE1]
               cnt_r <= cnt_r + 5'h1;
            end
            if (lfin) begin
               hold[c] <= 17'(acc_r >>> AVG_SHIFT);
            end
         end
      end
   end
   link_avg_a: assert property (@(posedge adc_clk_i) disable iff (!lrst_n)
      $changed(ldone_r) |-> $past(&full)) // see [RULE1]
      else $error("averages handed over before sixteen samples");

   ////////////////////////////////////////////////////////////////////
   // core side of the crossings: done toggle and fault pins
   logic [2:0] done_r;
   logic [FLT_W-1:0] flt_m_r;
   logic [FLT_W-1:0] flt_s_r;
   wire new_avg = done_r[2] ^ done_r[1];
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_r <= 3'b000;
         flt_m_r <= '0;
         flt_s_r <= '0;
      end else begin
         done_r <= {done_r[1:0], ldone_r};
         flt_m_r <= fault_i;
         flt_s_r <= flt_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // calibration trims, loaded with factory values at reset
   logic [10:0] igain_r;
   logic [10:0] ioff_r;
   logic signed [15:0] voff_r;
   logic [10:0] vgain_r;
   logic [10:0] noff_r;
   logic [10:0] ngain_r;
   logic wr_fire;
   logic [7:0] cmd_r;
   logic [7:0] wlo_r;
   logic [7:0] sh_r;
   wire [15:0] wval = {sh_r, wlo_r};
   wire signed [15:0] wsv = wval;
   // out-of-range vout offsets saturate to the allowed window
   wire signed [15:0] voff_nxt = (wsv < VOFF_MIN) ? VOFF_MIN :
      (wsv > VOFF_MAX) ? VOFF_MAX : wsv; // see [RULE10]
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         igain_r <= IGAIN_DEF; // see [RULE5]
         ioff_r <= IOFF_DEF;
         voff_r <= VOFF_DEF;
         vgain_r <= VGAIN_DEF;
         noff_r <= NOFF_DEF;
         ngain_r <= NGAIN_DEF;
      end else if (wr_fire) begin
         // exponents are fixed, so only mantissas are stored
         case (cmd_r)
            CMD_IGAIN: igain_r <= wval[10:0]; // see [RULE2]
            CMD_IOFF: ioff_r <= wval[10:0]; // see [RULE3] see [RULE4]
            CMD_VOFF: voff_r <= voff_nxt; // see [RULE10]
            CMD_VGAIN: vgain_r <= wval[10:0]; // see [RULE11]
            CMD_NOFF: noff_r <= wval[10:0]; // see [RULE14]
            CMD_NGAIN: ngain_r <= wval[10:0]; // see [RULE11]
            default: ;
         endcase
      end
   end
   voff_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (voff_r >= VOFF_MIN) && (voff_r <= VOFF_MAX)) // see [RULE10]
      else $error("vout offset outside its window");

   ////////////////////////////////////////////////////////////////////
   // scaling; current has no temperature term, see [RULE8]
   wire signed [27:0] ip = hold[0] * $signed(igain_r);
   wire signed [17:0] isum = 18'(ip >>> 7) + 18'($signed(ioff_r));
   wire signed [27:0] vp = hold[1] * $signed(vgain_r);
   wire signed [19:0] vsum = 20'(hold[1]) + 20'(vp >>> 8) +
      20'(voff_r); // see [RULE12]
   wire signed [27:0] np = hold[2] * $signed(ngain_r);
   wire signed [19:0] nsum = 20'(hold[2]) + 20'(np >>> 8) +
      20'($signed(noff_r)); // see [RULE12]
   // negative sums clamp to zero, sinking current included
   wire [9:0] imant = isum[17] ? 10'h0 : (isum > 18'sd1023) ?
      MANT_MAX : isum[9:0]; // see [RULE6]
   wire [15:0] vmant = vsum[19] ? 16'h0 : (vsum > 20'sd65535) ?
      16'hffff : vsum[15:0]; // see [RULE9]
   wire [9:0] nmant = nsum[19] ? 10'h0 : (nsum > 20'sd1023) ?
      MANT_MAX : nsum[9:0];
   logic [15:0] rd_iout_r;
   logic [15:0] rd_vout_r;
   logic [15:0] rd_vin_r;
   // all three readbacks move together on one handover
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_iout_r <= {EXP_IOUT, 11'h0};
         rd_vout_r <= 16'h0;
         rd_vin_r <= {EXP_VIN, 11'h0};
      end else if (new_avg) begin
         rd_iout_r <= {EXP_IOUT, 1'b0, imant}; // see [RULE7]
         rd_vout_r <= vmant; // see [RULE9]
         rd_vin_r <= {EXP_VIN, 1'b0, nmant}; // see [RULE13]
      end
   end
   iout_fmt_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_iout_r[15:10] == {EXP_IOUT, 1'b0}) // see [RULE7]
      else $error("current reading format broken");
   vin_fmt_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_vin_r[15:10] == {EXP_VIN, 1'b0}) // see [RULE13]
      else $error("input voltage reading format broken");
   sink_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      new_avg && isum < 0 |=> rd_iout_r[10:0] == 11'h0) // see [RULE6]
      else $error("sinking current not reported as zero");

   ////////////////////////////////////////////////////////////////////
   // status registers built from the synchronised fault levels
   wire [15:0] sword;
   wire [7:0] svout = {flt_s_r[F_VOV], 2'b00, flt_s_r[F_VUV], 4'h0};
   wire any_low = flt_s_r[F_OFF] | flt_s_r[F_VOV] | flt_s_r[F_IOC] |
      flt_s_r[F_VINUV] | flt_s_r[F_TEMP] | flt_s_r[F_COMM];
   wire vout_any = flt_s_r[F_VOV] | flt_s_r[F_VUV]; // see [RULE21]
   wire iout_any = flt_s_r[F_IOC] | flt_s_r[F_IOW]; // see [RULE21]
   wire none_above = ~any_low & (vout_any | iout_any | flt_s_r[F_PGN]);
   assign sword = {vout_any, iout_any, 2'b00, flt_s_r[F_PGN], 3'b000,
      1'b0, flt_s_r[F_OFF], flt_s_r[F_VOV], flt_s_r[F_IOC],
      flt_s_r[F_VINUV], flt_s_r[F_TEMP], flt_s_r[F_COMM],
      none_above}; // see [RULE15] see [RULE16] see [RULE17] see [RULE20]
   wire [7:0] sbyte = sword[7:0]; // see [RULE17]
   stat_unused_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sword[7] == 1'b0 && sword[13:12] == 2'b00 &&
      svout[6:5] == 2'b00 && svout[3:0] == 4'h0) // see [RULE20]
      else $error("unused status bit set");
   stat_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      flt_s_r[F_VOV] |-> sword[SB_VOV] && sword[SW_VOUT] &&
      svout[SV_OV]) // see [RULE21]
      else $error("summary not following overvoltage flag");
   stat_uv_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      flt_s_r[F_VUV] == svout[SV_UV] && (!svout[SV_UV] || sword[SW_VOUT]))
      else $error("undervoltage flag mismatch"); // see [RULE18]

   ////////////////////////////////////////////////////////////////////
   // read selection; fixed exponents are inserted here
   function automatic logic [15:0] rd_sel(input logic [7:0] c);
      case (c)
         CMD_IGAIN: rd_sel = {EXP_IGAIN, igain_r}; // see [RULE2]
         CMD_IOFF: rd_sel = {EXP_IOUT, ioff_r}; // see [RULE3] see [RULE4]
         CMD_SBYTE: rd_sel = {8'h00, sbyte};
         CMD_SWORD: rd_sel = sword;
         CMD_SVOUT: rd_sel = {8'h00, svout}; // see [RULE18]
         CMD_RVIN: rd_sel = rd_vin_r;
         CMD_RVOUT: rd_sel = rd_vout_r;
         CMD_RIOUT: rd_sel = rd_iout_r;
         CMD_VOFF: rd_sel = voff_r; // see [RULE10]
         CMD_VGAIN: rd_sel = {EXP_VGAIN, vgain_r}; // see [RULE11]
         CMD_NOFF: rd_sel = {EXP_VIN, noff_r}; // see [RULE14]
         CMD_NGAIN: rd_sel = {EXP_VGAIN, ngain_r}; // see [RULE11]
         default: rd_sel = {RD_IDLE, RD_IDLE};
      endcase
   endfunction
   gain_exp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (rd_sel(CMD_IGAIN) >> 11) == 16'(EXP_IGAIN) &&
      (rd_sel(CMD_NOFF) >> 11) == 16'(EXP_VIN)) // see [RULE2] see [RULE14]
      else $error("fixed exponent lost on readback");

   ////////////////////////////////////////////////////////////////////
   // host bus slave, oversampled; first sync stage feeds only the second
   logic [2:0] scl_r;
   logic [2:0] sda_r;
   pmt_st_type st_r;
   logic [3:0] bit_r;
   logic ack_r;
   logic wb_r;
   logic [1:0] rb_r;
   logic [15:0] tx_r;
   logic oe_r;
   wire scl_rise = scl_r[1] & ~scl_r[2];
   wire scl_fall = ~scl_r[1] & scl_r[2];
   wire sda_s = sda_r[1];
   wire start_det = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
   wire stop_det = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];
   wire byte_end = scl_fall & ~ack_r & (bit_r == 4'h8);
   wire addr_hit = (sh_r[7:1] == BUS_ADDR);
   wire tx_rd_go = (st_r == S_ADDR) & ack_r & sh_r[0];
   wire [1:0] rb_nxt = rb_r + {1'b0, ack_r & (st_r == S_RDATA) & ~rb_r[1]};
   wire [7:0] tx_byte = (rb_nxt == 2'h0) ? tx_r[7:0] :
      (rb_nxt == 2'h1) ? tx_r[15:8] : RD_IDLE;
   wire [2:0] bidx = 3'(4'h7 - (ack_r ? 4'h0 : bit_r));
   assign wr_fire = byte_end & (st_r == S_WDATA) & wb_r;
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_r;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_r <= 3'b111;
         sda_r <= 3'b111;
      end else begin
         scl_r <= {scl_r[1:0], scl_i};
         sda_r <= {sda_r[1:0], sda_i};
      end
   end
   // bit engine: sample on rise, drive and acknowledge on fall
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= S_IDLE;
         bit_r <= 4'h0;
         ack_r <= 1'b0;
         wb_r <= 1'b0;
         rb_r <= 2'h0;
         sh_r <= 8'h0;
         cmd_r <= 8'h0;
         wlo_r <= 8'h0;
         tx_r <= 16'h0;
         oe_r <= 1'b0;
      end else if (start_det || stop_det) begin
         st_r <= start_det ? S_ADDR : S_IDLE;
         bit_r <= 4'h0;
         ack_r <= 1'b0;
         wb_r <= 1'b0;
         rb_r <= 2'h0;
         oe_r <= 1'b0;
      end else if (scl_rise && st_r != S_IDLE) begin
         if (!ack_r) begin
            sh_r <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
         end else if (st_r == S_RDATA && sda_s) begin
            st_r <= S_IDLE; // host ended the read
         end
      end else if (byte_end) begin
         ack_r <= 1'b1;
         bit_r <= 4'h0;
         case (st_r)
            S_ADDR: begin
               oe_r <= addr_hit;
               if (!addr_hit) begin
                  st_r <= S_IDLE;
               end else if (sh_r[0]) begin
                  tx_r <= rd_sel(cmd_r); // see [RULE20] see [RULE19]
               end
            end
            S_CMD: begin
               cmd_r <= sh_r;
               oe_r <= 1'b1;
            end
            S_WDATA: begin
               wlo_r <= sh_r;
               wb_r <= ~wb_r;
               oe_r <= 1'b1;
            end
            default: oe_r <= 1'b0; // host acknowledges read bytes
         endcase
      end else if (scl_fall && st_r != S_IDLE) begin
         ack_r <= 1'b0;
         case (st_r)
            S_ADDR: st_r <= !ack_r ? S_ADDR : tx_rd_go ? S_RDATA : S_CMD;
            S_CMD: st_r <= ack_r ? S_WDATA : S_CMD;
            default: ;
         endcase
         if ((st_r == S_RDATA) || (ack_r && tx_rd_go)) begin
            rb_r <= (st_r == S_RDATA) ? rb_nxt : 2'h0;
            oe_r <= ~tx_byte[bidx];
         end else begin
            oe_r <= 1'b0;
         end
      end
   end
   rd_atomic_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      st_r == S_RDATA && $past(st_r) == S_RDATA && !$past(start_det)
      |-> $stable(tx_r)) // see [RULE20]
      else $error("read word changed during a transfer");
   tmr_req_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $changed(req_tgl_r) |-> $past(tmr_r) == 32'h0) // see [RULE1]
      else $error("burst request off the interval");
endmodule
`default_nettype wire

// ==== pmt_host_model.sv ====
// host side of the management bus: start, stop and word transfers
// assumes an open-drain data wire with pull-up; device pulls via its enable
`timescale 1ns/1ns
`default_nettype none
module pmt_host_model #(
   parameter int HALF = 8
) (
   input wire logic clock_i,
   input wire logic dev_sda_i,
   input wire logic dev_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull_r;
   initial begin
      pull_r = 1'b0;
      scl_o = 1'b1;
   end
   // wired-and with pull-up: a released line reads high, never stale
   assign sda_o = ~(pull_r | (dev_oe_i & ~dev_sda_i));

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // data moves only while the clock is low, two cycles after its fall
   task automatic put_bit(input logic b);
      tick(2);
      pull_r <= ~b;
      tick(HALF);
      scl_o <= 1'b1;
      tick(HALF);
      scl_o <= 1'b0;
   endtask
   task automatic get_bit(output logic b);
      tick(2);
      pull_r <= 1'b0;
      tick(HALF);
      scl_o <= 1'b1;
      tick(HALF / 2);
      b = sda_o;
      tick(HALF / 2);
      scl_o <= 1'b0;
   endtask
   // start, or repeated start when the clock is already low
   task automatic start_cond();
      tick(2);
      pull_r <= 1'b0;
      tick(HALF);
      scl_o <= 1'b1;
      tick(HALF);
      pull_r <= 1'b1;
      tick(HALF);
      scl_o <= 1'b0;
   endtask
   task automatic stop_cond();
      tick(2);
      pull_r <= 1'b1;
      tick(HALF);
      scl_o <= 1'b1;
      tick(HALF);
      pull_r <= 1'b0;
      tick(HALF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(b);
      ack = ~b;
   endtask
   // last byte is answered with a nack to end the read
   task automatic recv_byte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      put_bit(last);
   endtask
   task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
         input logic [15:0] d, output logic ack);
      logic k0, k1, k2, k3;
      start_cond();
      send_byte({a, 1'b0}, k0);
      send_byte(cmd, k1);
      send_byte(d[7:0], k2);
      send_byte(d[15:8], k3);
      stop_cond();
      ack = k0 & k1 & k2 & k3;
   endtask
   // word read, low byte first, through a repeated start
   task automatic read_word(input logic [6:0] a, input logic [7:0] cmd,
         output logic [15:0] d, output logic ack);
      logic k0, k1, k2;
      start_cond();
      send_byte({a, 1'b0}, k0);
      send_byte(cmd, k1);
      start_cond();
      send_byte({a, 1'b1}, k2);
      recv_byte(1'b0, d[7:0]);
      recv_byte(1'b1, d[15:8]);
      stop_cond();
      ack = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire

// ==== tb_power_module_telemetry_status.sv ====
// self-checking bench: bus reads and writes of trims, readbacks, status
// assumes a free-running sample link at 160 ns beside the 4 ns core clock
`timescale 1ns/1ns
`default_nettype none
module tb_power_module_telemetry_status;
   import pmt_pkg::*;
   localparam int INT = 2500;
   localparam logic [6:0] ADDR = 7'h28;
   localparam logic [10:0] IG = 11'h080;
   localparam logic [15:0] WTAB [9] = '{16'h0040, 16'h8020, 16'h8001,
      16'h4010, 16'h4001, 16'h0008, 16'h0004, 16'h0002, 16'h0801};
   localparam logic [7:0] SVTAB [9] = '{8'h00, 8'h80, 8'h10, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic adc_clk = 1'b0;
   logic valid = 1'b0;
   logic [1:0] chan = 2'h0;
   logic [1:0] ph = 2'h0;
   logic alt = 1'b0;
   logic feed = 1'b0;
   logic [15:0] sdata = 16'h0000;
   logic [FLT_W-1:0] fault = '0;
   logic scl, sda, dut_sda, dut_oe;
   logic [15:0] raw [3] = '{16'h0000, 16'h0000, 16'h0000};
   int errors = 0;
   int n_compared = 0;

   ////////////////////////////////////////////////////////////////////////
   always #2 clock_i = ~clock_i;
   // link clock: unrelated phase to the core clock
   initial begin
      #37;
      forever #80 adc_clk = ~adc_clk;
   end
   // samples rotate over channels; alternating +8 makes the mean raw+4
   always @(posedge adc_clk) begin
      valid <= rst_n_i & feed;
      chan <= ph;
      sdata <= raw[ph] + (alt ? 16'h0008 : 16'h0000);
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
         alt <= ~alt;
      end
   end

   pmt_host_model host (.clock_i(clock_i), .dev_sda_i(dut_sda),
      .dev_oe_i(dut_oe), .scl_o(scl), .sda_o(sda));
   pmt_telemetry #(.INTERVAL(INT), .IGAIN_DEF(IG)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
      .sda_o(dut_sda), .sda_oe_o(dut_oe), .adc_clk_i(adc_clk),
      .sample_valid_i(valid), .sample_chan_i(chan),
      .sample_data_i(sdata), .fault_i(fault));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] d;
      logic k;
      host.read_word(ADDR, cmd, d, k);
      chk({15'h0000, k}, 16'h0001);
      chk(d, exp);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic k;
      host.write_word(ADDR, cmd, d, k);
      chk({15'h0000, k}, 16'h0001);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog: the sequence needs about 70k cycles
   initial begin
      repeat (95000) @(posedge clock_i);
      errors++;
      tally_and_finish();
   end

   initial begin
      logic [15:0] d;
      logic k;
      // reset must also cover two link clock edges
      repeat (12) @(posedge clock_i);
      repeat (2) @(posedge adc_clk);
      @(posedge clock_i);
      rst_n_i <= 1'b1;
      host.tick(8);
      // reset values; the link feeds nothing yet, so no burst can finish
      rd(CMD_RIOUT, 16'he000);
      rd(CMD_RVOUT, 16'h0000);
      rd(CMD_RVIN, 16'hd800);
      rd(CMD_SBYTE, 16'h0000);
      rd(CMD_SWORD, 16'h0000);
      rd(CMD_SVOUT, 16'h0000);
      rd(CMD_IGAIN, {EXP_IGAIN, IG});
      rd(CMD_IOFF, {EXP_IOUT, 11'h000});
      // averaged readbacks with factory trims
      raw[0] = 16'd100;
      raw[1] = 16'd4660;
      raw[2] = 16'd300;
      feed = 1'b1;
      host.tick(3 * INT);
      rd(CMD_RIOUT, {EXP_IOUT, 11'd104});
      rd(CMD_RVOUT, 16'd4664);
      rd(CMD_RVIN, {EXP_VIN, 11'd304});
      // trims written and read back; vout offset saturates at 127
      wr(CMD_IOFF, 16'h07f0);
      rd(CMD_IOFF, {EXP_IOUT, 11'h7f0});
      wr(CMD_VGAIN, 16'h0010);
      rd(CMD_VGAIN, {EXP_VGAIN, 11'h010});
      wr(CMD_VOFF, 16'h00c8);
      rd(CMD_VOFF, 16'h007f);
      wr(CMD_NOFF, 16'h07ff);
      rd(CMD_NOFF, {EXP_VIN, 11'h7ff});
      wr(CMD_RIOUT, 16'h1234);
      host.tick(3 * INT);
      // 104-16; 4664+291+127; 304-1
      rd(CMD_RIOUT, {EXP_IOUT, 11'd88});
      rd(CMD_RVOUT, 16'd5082);
      rd(CMD_RVIN, {EXP_VIN, 11'd303});
      // sinking current reads as zero
      raw[0] = 16'hffce;
      host.tick(3 * INT);
      rd(CMD_RIOUT, 16'he000);
      rd(8'h00, 16'hffff);
      host.read_word(7'h29, CMD_RVIN, d, k);
      chk({15'h0000, k}, 16'h0000);
      // each fault alone, then all together
      for (int i = 0; i < FLT_W; i++) begin
         @(posedge clock_i);
         fault <= FLT_W'(1) << i;
         rd(CMD_SWORD, WTAB[i]);
         rd(CMD_SBYTE, {8'h00, WTAB[i][7:0]});
         rd(CMD_SVOUT, {8'h00, SVTAB[i]});
      end
      @(posedge clock_i);
      fault <= '1;
      rd(CMD_SWORD, 16'hc87e);
      rd(CMD_SVOUT, 16'h0090);
      tally_and_finish();
   end
endmodule
`default_nettype wire
